// File: design/fsp_pkg.sv
// Purpose: Shared constants and types for the protection command host.
// Assumes: 16-bit flash bus, 22-bit word address, 40 MHz clock.
// Notes:   Register offsets are byte addresses on the local port.
package fsp_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;

  // ------------------------------------------------------------
  // Local register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_PWD0   = 8'h20;
  localparam logic [7:0] REG_PWD3   = 8'h2c;
  localparam int ST_BUSY  = 0;
  localparam int ST_ERR   = 1;
  localparam int ST_DQ0   = 2;
  localparam int ST_MODE  = 4;

  // ------------------------------------------------------------
  // Bus codes
  // ------------------------------------------------------------
  localparam logic [21:0] UNLOCK_A1  = 22'h000555;
  localparam logic [21:0] UNLOCK_A2  = 22'h0002aa;
  localparam logic [21:0] ZERO_ADDR  = 22'h000000;
  localparam logic [15:0] KEY1       = 16'h00aa;
  localparam logic [15:0] KEY2       = 16'h0055;
  localparam logic [15:0] ENT_LOCK   = 16'h0040;
  localparam logic [15:0] ENT_PW     = 16'h0060;
  localparam logic [15:0] ENT_NV     = 16'h00c0;
  localparam logic [15:0] ENT_FRZ    = 16'h0050;
  localparam logic [15:0] ENT_VOL    = 16'h00e0;
  localparam logic [15:0] PROG_CODE  = 16'h00a0;
  localparam logic [15:0] EXIT1      = 16'h0090;
  localparam logic [15:0] ZERO_DATA  = 16'h0000;
  localparam logic [15:0] BIT_CLR    = 16'h0001;
  localparam logic [15:0] ERASE1     = 16'h0080;
  localparam logic [15:0] ERASE2     = 16'h0030;
  localparam logic [15:0] PWU_START  = 16'h0025;
  localparam logic [15:0] PWU_KEY    = 16'h0003;
  localparam logic [15:0] PWU_END    = 16'h0029;
  localparam logic [15:0] RESET_CODE = 16'h00f0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ     = 40;
  localparam int PHASE_NS    = 50;
  localparam int PHASE_CYC   = (PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] PHASE_LAST = 4'(PHASE_CYC - 1);
  localparam logic [3:0] SYNC_LAST  = 4'(SYNC_STAGES - 1);

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ENTER_LOCK, OP_ENTER_PW, OP_ENTER_NV, OP_ENTER_FRZ,
    OP_ENTER_VOL, OP_EXIT, OP_RESET, OP_PROG, OP_DYB_CLR,
    OP_READ, OP_UNLOCK, OP_ERASE_ALL
  } fsp_op_e;

  typedef enum logic [2:0] {
    MODE_ARRAY, MODE_LOCK, MODE_PW, MODE_NV, MODE_FRZ, MODE_VOL
  } fsp_mode_e;

  typedef struct packed {
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fsp_cycle_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic              dq_oe_n;
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
  } fsp_pins_s;

endpackage : fsp_pkg

// File: design/fsp_sync.sv
// Purpose: Two-stage synchroniser for the flash data pins.
// Assumes: Pins change asynchronously to sys_clk_in.
// Notes:   Only stage two is visible outside.
`timescale 1ns/100ps
`default_nettype none
module fsp_sync
  import fsp_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  // Data
  input  wire logic [DATA_W-1:0] d_in,
  output logic      [DATA_W-1:0] q_out
);

  logic [DATA_W-1:0] meta_ff;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      meta_ff <= 16'h0000;
      q_out   <= 16'h0000;
    end else begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end

endmodule : fsp_sync
`default_nettype wire

// File: design/fsp_bus_cycle.sv
// Purpose: Runs one flash bus cycle, read or write, on the pins.
// Assumes: Data input already synchronised, SYNC_STAGES late.
// Notes:   Setup, strobe and hold each last PHASE_CYC clocks.
`timescale 1ns/100ps
`default_nettype none
module fsp_bus_cycle
  import fsp_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  // Cycle request
  input  wire logic              req_valid_in,
  input  wire fsp_cycle_s        req_in,
  output logic                   done_out,
  output logic      [DATA_W-1:0] rdata_out,
  // Flash side
  input  wire logic [DATA_W-1:0] dq_sync_in,
  output fsp_pins_s              pins_out
);

  typedef enum logic [2:0] {
    CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_SAMPLE, CYC_HOLD
  } fsp_cyc_e;

  fsp_cyc_e   state_ff;
  logic [3:0] cnt_ff;
  logic       rd_ff;
  logic       cnt_end;

  // Sample phase covers the synchroniser delay
  assign cnt_end = (state_ff == CYC_SAMPLE) ? (cnt_ff == SYNC_LAST)
                                            : (cnt_ff == PHASE_LAST);

  // ------------------------------------------------------------
  // Phase divider
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || state_ff == CYC_IDLE || cnt_end) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_ff <= CYC_IDLE;
    end else begin
      unique case (state_ff)
        CYC_IDLE:   if (req_valid_in) state_ff <= CYC_SETUP;
        CYC_SETUP:  if (cnt_end) state_ff <= CYC_STROBE;
        CYC_STROBE: if (cnt_end) state_ff <= rd_ff ? CYC_SAMPLE : CYC_HOLD;
        CYC_SAMPLE: if (cnt_end) state_ff <= CYC_HOLD;
        CYC_HOLD:   if (cnt_end) state_ff <= CYC_IDLE;
        default:    state_ff <= CYC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pins_out  <= '{addr: 22'h000000, dq: 16'h0000, dq_oe_n: 1'b1,
                     ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      rd_ff     <= 1'b0;
      done_out  <= 1'b0;
      rdata_out <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      unique case (state_ff)
        CYC_IDLE: if (req_valid_in) begin
          rd_ff            <= req_in.rd;
          pins_out.addr    <= req_in.addr;
          pins_out.dq      <= req_in.data;
          pins_out.dq_oe_n <= req_in.rd;
          pins_out.ce_n    <= 1'b0;
        end
        CYC_SETUP: if (cnt_end) begin
          pins_out.we_n <= rd_ff;
          pins_out.oe_n <= ~rd_ff;
        end
        // Device latches write data on the rising strobe
        CYC_STROBE: if (cnt_end && !rd_ff) pins_out.we_n <= 1'b1;
        CYC_SAMPLE: if (cnt_end) begin
          rdata_out     <= dq_sync_in;
          pins_out.oe_n <= 1'b1;
        end
        CYC_HOLD: if (cnt_end) begin
          pins_out.ce_n    <= 1'b1;
          pins_out.dq_oe_n <= 1'b1;
          done_out         <= 1'b1;
        end
        default: done_out <= 1'b0;
      endcase
    end
  end

endmodule : fsp_bus_cycle
`default_nettype wire

// File: design/fsp_host.sv
// Purpose: Host controller issuing sector protection command sequences.
// Assumes: Flash in 16-bit mode; software polls busy in STATUS.
// Notes:   Refused commands set a sticky error bit, write 1 clears.
`timescale 1ns/100ps
`default_nettype none
module fsp_host
  import fsp_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  // Register port
  input  wire logic [REG_AW-1:0] reg_addr_in,
  input  wire logic [REG_DW-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [REG_DW-1:0] reg_rdata_out,
  // Flash pins
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output fsp_pins_s              flash_pins_out,
  output logic                   accel_out
);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} fsp_seq_e;

  fsp_seq_e          seq_ff;
  fsp_op_e           op_ff;
  fsp_mode_e         mode_ff;
  logic [2:0]        step_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [DATA_W-1:0] pwd_ff [4];
  logic [DATA_W-1:0] rdata_ff;
  logic              err_ff;
  logic              dq0_ff;
  logic              accel_ff;
  logic              req_valid_ff;
  fsp_cycle_s        req_ff;

  logic [DATA_W-1:0] dq_sync;
  logic [DATA_W-1:0] cyc_rdata;
  logic              cyc_done;
  logic              cmd_wr;
  logic              cmd_ok;
  logic              busy;
  logic              last_step;
  logic              sw_wr;
  fsp_op_e           cmd_op;
  logic [DATA_W-1:0] pw_word;
  logic [2:0]        pw_sel;

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] pwd_slot(input logic [REG_AW-1:0] a);
    // Bit 2 flags a hit, bits 1:0 give the portion
    logic [2:0] s;
    s = 3'h0;
    if (a >= REG_PWD0 && a <= REG_PWD3 && a[1:0] == 2'h0) begin
      s = {1'b1, a[3:2]};
    end
    return s;
  endfunction : pwd_slot

  function automatic logic [ADDR_W-1:0] pw_addr(input logic [1:0] p);
    return {20'h00000, p};
  endfunction : pw_addr

  function automatic logic [DATA_W-1:0] enter_code(input fsp_op_e op);
    logic [DATA_W-1:0] c;
    unique case (op)
      OP_ENTER_LOCK: c = ENT_LOCK;
      OP_ENTER_PW:   c = ENT_PW;
      OP_ENTER_NV:   c = ENT_NV;
      OP_ENTER_FRZ:  c = ENT_FRZ;
      default:       c = ENT_VOL;
    endcase
    return c;
  endfunction : enter_code

  function automatic fsp_mode_e enter_mode(input fsp_op_e op);
    fsp_mode_e m;
    unique case (op)
      OP_ENTER_LOCK: m = MODE_LOCK;
      OP_ENTER_PW:   m = MODE_PW;
      OP_ENTER_NV:   m = MODE_NV;
      OP_ENTER_FRZ:  m = MODE_FRZ;
      default:       m = MODE_VOL;
    endcase
    return m;
  endfunction : enter_mode

  function automatic logic is_enter(input fsp_op_e op);
    return op inside {OP_ENTER_LOCK, OP_ENTER_PW, OP_ENTER_NV,
                      OP_ENTER_FRZ, OP_ENTER_VOL};
  endfunction : is_enter

  function automatic logic op_legal(input fsp_op_e op, input fsp_mode_e md);
    logic ok;
    unique case (op)
      OP_RESET:                    ok = 1'b1;
      OP_EXIT, OP_PROG, OP_READ:   ok = (md != MODE_ARRAY);
      OP_DYB_CLR:                  ok = (md == MODE_VOL);
      OP_UNLOCK:                   ok = (md == MODE_PW);
      OP_ERASE_ALL:                ok = (md == MODE_NV);
      default:                     ok = (md == MODE_ARRAY);
    endcase
    return ok;
  endfunction : op_legal

  // Index of the last bus cycle of an operation
  function automatic logic [2:0] op_last(input fsp_op_e op, input fsp_mode_e md);
    logic [2:0] n;
    unique case (op)
      OP_RESET:  n = 3'h0;
      OP_READ:   n = (md == MODE_PW) ? 3'h3 : 3'h0;
      OP_UNLOCK: n = 3'h6;
      OP_EXIT, OP_PROG, OP_DYB_CLR, OP_ERASE_ALL: n = 3'h1;
      default:   n = 3'h2;
    endcase
    return n;
  endfunction : op_last

  // ------------------------------------------------------------
  // Bus cycle builder
  // ------------------------------------------------------------
  // Open address and data bits are driven as zero
  function automatic fsp_cycle_s op_cycle(
    input fsp_op_e           op,
    input fsp_mode_e         md,
    input logic [2:0]        st,
    input logic [ADDR_W-1:0] sa,
    input logic [DATA_W-1:0] wd,
    input logic [DATA_W-1:0] pw
  );
    fsp_cycle_s c;
    c = '{rd: 1'b0, addr: ZERO_ADDR, data: ZERO_DATA};
    unique case (op)
      OP_EXIT:      c.data = (st == 3'h0) ? EXIT1 : ZERO_DATA;
      OP_RESET:     c.data = RESET_CODE;
      OP_ERASE_ALL: c.data = (st == 3'h0) ? ERASE1 : ERASE2;
      OP_PROG, OP_DYB_CLR: begin
        if (st == 3'h0) begin
          c.data = PROG_CODE;
        end else begin
          unique case (md)
            MODE_LOCK: c.data = wd;
            MODE_PW: begin
              c.addr = pw_addr(sa[1:0]);
              c.data = wd;
            end
            MODE_NV:   c.addr = sa;
            MODE_VOL: begin
              c.addr = sa;
              c.data = (op == OP_DYB_CLR) ? BIT_CLR : ZERO_DATA;
            end
            default:   c.data = ZERO_DATA;
          endcase
        end
      end
      OP_READ: begin
        c.rd = 1'b1;
        unique case (md)
          MODE_PW:           c.addr = pw_addr(st[1:0]);
          MODE_NV, MODE_VOL: c.addr = sa;
          default:           c.addr = ZERO_ADDR;
        endcase
      end
      OP_UNLOCK: begin
        unique case (st)
          3'h0:    c.data = PWU_START;
          3'h1:    c.data = PWU_KEY;
          3'h6:    c.data = PWU_END;
          default: begin
            c.addr = pw_addr(2'(st - 3'h2));
            c.data = pw;
          end
        endcase
      end
      default: begin
        unique case (st)
          3'h0:    c = '{rd: 1'b0, addr: UNLOCK_A1, data: KEY1};
          3'h1:    c = '{rd: 1'b0, addr: UNLOCK_A2, data: KEY2};
          default: c = '{rd: 1'b0, addr: UNLOCK_A1, data: enter_code(op)};
        endcase
      end
    endcase
    return c;
  endfunction : op_cycle

  // ------------------------------------------------------------
  // Command acceptance
  // ------------------------------------------------------------
  assign busy      = (seq_ff != SEQ_IDLE);
  assign cmd_wr    = reg_wr_in && (reg_addr_in == REG_CMD);
  assign cmd_op    = fsp_op_e'(reg_wdata_in[3:0]);
  assign cmd_ok    = !busy && (reg_wdata_in[3:0] <= 4'(OP_ERASE_ALL))
                     && op_legal(cmd_op, mode_ff);
  assign last_step = (step_ff == op_last(op_ff, mode_ff));
  assign sw_wr     = reg_wr_in && !busy;
  assign pw_word   = pwd_ff[2'(step_ff - 3'h2)];
  assign pw_sel    = pwd_slot(reg_addr_in);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      seq_ff       <= SEQ_IDLE;
      op_ff        <= OP_RESET;
      step_ff      <= 3'h0;
      req_valid_ff <= 1'b0;
      req_ff       <= '{rd: 1'b0, addr: 22'h000000, data: 16'h0000};
    end else begin
      req_valid_ff <= 1'b0;
      unique case (seq_ff)
        SEQ_IDLE: if (cmd_wr && cmd_ok) begin
          op_ff   <= cmd_op;
          step_ff <= 3'h0;
          seq_ff  <= SEQ_ISSUE;
        end
        SEQ_ISSUE: begin
          req_ff       <= op_cycle(op_ff, mode_ff, step_ff, addr_ff,
                                   wdata_ff, pw_word);
          req_valid_ff <= 1'b1;
          seq_ff       <= SEQ_WAIT;
        end
        SEQ_WAIT: if (cyc_done) begin
          if (last_step) begin
            seq_ff <= SEQ_IDLE;
          end else begin
            step_ff <= step_ff + 3'h1;
            seq_ff  <= SEQ_ISSUE;
          end
        end
        default: seq_ff <= SEQ_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Mode tracking
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mode_ff <= MODE_ARRAY;
    end else if (seq_ff == SEQ_WAIT && cyc_done && last_step) begin
      if (is_enter(op_ff)) begin
        mode_ff <= enter_mode(op_ff);
      end else if (op_ff == OP_EXIT || op_ff == OP_RESET) begin
        mode_ff <= MODE_ARRAY;
      end
    end
  end

  // Accelerate input high for the whole set or clear sequence
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      accel_ff <= 1'b0;
    end else if (cmd_wr && cmd_ok) begin
      accel_ff <= (cmd_op == OP_DYB_CLR) || (cmd_op == OP_PROG &&
                  (mode_ff == MODE_NV || mode_ff == MODE_VOL));
    end else if (!busy) begin
      accel_ff <= 1'b0;
    end
  end

  assign accel_out = accel_ff;

  // ------------------------------------------------------------
  // Read results
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_ff <= 16'h0000;
      dq0_ff   <= 1'b0;
    end else if (seq_ff == SEQ_WAIT && cyc_done && req_ff.rd) begin
      rdata_ff <= cyc_rdata;
      dq0_ff   <= cyc_rdata[0];
    end
  end

  // Password store: software writes while idle, reads fill it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) begin
        pwd_ff[i] <= 16'h0000;
      end
    end else if (seq_ff == SEQ_WAIT && cyc_done && req_ff.rd
                 && mode_ff == MODE_PW) begin
      pwd_ff[step_ff[1:0]] <= cyc_rdata;
    end else if (sw_wr && pw_sel[2]) begin
      pwd_ff[pw_sel[1:0]] <= reg_wdata_in[15:0];
    end
  end

  // ------------------------------------------------------------
  // Operand registers
  // ------------------------------------------------------------
  // Frozen while busy so a sequence sees stable operands
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      addr_ff  <= 22'h000000;
      wdata_ff <= 16'h0000;
    end else if (sw_wr) begin
      if (reg_addr_in == REG_ADDR) begin
        addr_ff <= reg_wdata_in[ADDR_W-1:0];
      end
      if (reg_addr_in == REG_WDATA) begin
        wdata_ff <= reg_wdata_in[DATA_W-1:0];
      end
    end
  end

  // Sticky error; a new refusal wins over the clear
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      err_ff <= 1'b0;
    end else if (cmd_wr && !cmd_ok) begin
      err_ff <= 1'b1;
    end else if (reg_wr_in && reg_addr_in == REG_STATUS
                 && reg_wdata_in[ST_ERR]) begin
      err_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !reg_rd_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (pw_sel[2]) begin
      reg_rdata_out <= {16'h0000, pwd_ff[pw_sel[1:0]]};
    end else begin
      unique case (reg_addr_in)
        REG_CMD:    reg_rdata_out <= {28'h0000000, op_ff};
        REG_ADDR:   reg_rdata_out <= {10'h000, addr_ff};
        REG_WDATA:  reg_rdata_out <= {16'h0000, wdata_ff};
        REG_RDATA:  reg_rdata_out <= {16'h0000, rdata_ff};
        REG_STATUS: reg_rdata_out <= {25'h0000000, mode_ff, 1'b0,
                                      dq0_ff, err_ff, busy};
        default:    reg_rdata_out <= 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin side
  // ------------------------------------------------------------
  fsp_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .d_in       (flash_dq_in),
    .q_out      (dq_sync)
  );

  fsp_bus_cycle u_cycle (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .req_valid_in (req_valid_ff),
    .req_in       (req_ff),
    .done_out     (cyc_done),
    .rdata_out    (cyc_rdata),
    .dq_sync_in   (dq_sync),
    .pins_out     (flash_pins_out)
  );

endmodule : fsp_host
`default_nettype wire

// File: tb/fsp_flash_model.sv
// Purpose: Behavioural protected flash device on the host pins.
// Assumes: Commands latch on rising we_n; 128 sectors.
// Notes:   Program and erase finish at once.
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_model import fsp_pkg::*; (
  input  wire fsp_pins_s         pins_in,
  input  wire logic              accel_in,
  output logic      [DATA_W-1:0] dq_out
);
  // ----
  // Command decode
  // ----
  wire fsp_pins_s   p = pins_in;
  wire logic [7:0]  d = p.dq[7:0];
  wire logic [6:0]  sa = p.addr[21:15];
  wire logic [10:0] lo = p.addr[10:0];
  fsp_mode_e        md = MODE_ARRAY;
  logic [2:0]       unl = 3'h0, uc = 3'h0;
  logic             prg = 1'b0, ex = 1'b0, ers = 1'b0, frz = 1'b0;
  logic [15:0]      lkr = 16'h0, last = 16'h0, rv, password_portion [4];
  logic [127:0]     persistent_protect_bit = '1, volatile_protect_bit = '1;
  always @(posedge p.we_n) if (!p.ce_n) begin
    unl <= 3'h0;
    if (d == 8'hf0 && !prg) begin
      md <= MODE_ARRAY;
      uc <= 3'h0;
      ex <= 1'b0;
    end else if (md == MODE_ARRAY) begin
      if (lo == 11'h555 && d == 8'haa) unl <= 3'h1;
      if (unl == 3'h1 && lo == 11'h2aa && d == 8'h55) unl <= 3'h2;
      if (unl == 3'h2 && lo == 11'h555) md <= d == 8'h40 ? MODE_LOCK : d == 8'h60 ? MODE_PW
        : d == 8'hc0 ? MODE_NV : d == 8'h50 ? MODE_FRZ : d == 8'he0 ? MODE_VOL : MODE_ARRAY;
    end else if (prg) begin
      prg <= 1'b0;
      case (md)
        MODE_LOCK: lkr <= p.dq;
        MODE_PW:   password_portion[p.addr[1:0]] <= p.dq;
        MODE_NV:   if (accel_in) persistent_protect_bit[sa] <= 1'b0;
        MODE_FRZ:  frz <= 1'b1;
        default:   if (accel_in) volatile_protect_bit[sa] <= p.dq[0];
      endcase
    end else if (uc != 3'h0) begin
      uc <= uc == 3'h6 ? 3'h0 : uc + 3'h1;
      // A wrong portion drops out of the mode, so later reads expose it
      if (uc >= 3'h2 && uc <= 3'h5
          && {p.addr[1:0], p.dq} != {2'(uc - 3'h2), password_portion[2'(uc - 3'h2)]}) begin
        md <= MODE_ARRAY;
        uc <= 3'h0;
      end
    end else if (ex) begin
      ex <= 1'b0;
      if (d == 8'h00) md <= MODE_ARRAY;
    end else if (ers) begin
      ers <= 1'b0;
      if (d == 8'h30) persistent_protect_bit <= '1;
    end else begin
      prg <= d == 8'ha0;
      ex  <= d == 8'h90;
      ers <= d == 8'h80 && md == MODE_NV;
      if (d == 8'h25 && md == MODE_PW) uc <= 3'h1;
    end
  end
  always_comb begin
    case (md)
      MODE_LOCK: rv = lkr;
      MODE_PW:   rv = password_portion[p.addr[1:0]];
      MODE_NV:   rv = {15'h0, persistent_protect_bit[sa]};
      MODE_FRZ:  rv = {15'h0, !frz};
      MODE_VOL:  rv = {15'h0, volatile_protect_bit[sa]};
      default:   rv = 16'h0;
    endcase
  end
  always @(posedge p.oe_n) last <= rv;
  // Released bus inverts the last word so stale data never passes
  assign dq_out = (!p.ce_n && !p.oe_n) ? rv : ~last;
endmodule : fsp_flash_model
`default_nettype wire

// File: tb/fsp_host_asserts.sv
// Purpose: Pin sequencing and register read checks for the protection host.
// Assumes: Phases of two clocks each.
// Notes:   Bound to the top module.
`timescale 1ns/100ps
`default_nettype none
module fsp_host_asserts import fsp_pkg::*; (
  input wire logic              sys_clk_in,
  input wire logic              rst_in,
  input wire logic              reg_rd_in,
  input wire logic [REG_DW-1:0] reg_rdata_out,
  input wire fsp_pins_s         flash_pins_out
);
  // ----
  // Register read idle and bus cycle shape
  // ----
  wire logic we = flash_pins_out.we_n;
  wire logic ce = flash_pins_out.ce_n;
  wire logic oe = flash_pins_out.oe_n;
  wire logic de = flash_pins_out.dq_oe_n;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  AST_RD_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == '0)
    else $error("read data outside slot");
  AST_WE_IN_CE: assert property (!we |-> !ce)
    else $error("write strobe without select");
  AST_WE_PULSE: assert property ($fell(we) |-> !we [*2] ##1 we)
    else $error("write strobe length");
  AST_CE_HOLD: assert property ($fell(ce) |-> !ce [*6])
    else $error("select too short");
  AST_WR_DRIVE: assert property (!we |-> !de && $stable(flash_pins_out.addr)
    && $stable(flash_pins_out.dq))
    else $error("write data not held");
  AST_NO_FIGHT: assert property (!oe |-> de && we)
    else $error("bus contention");
  AST_OE_PULSE: assert property ($fell(oe) |-> !oe [*4] ##1 oe)
    else $error("read strobe length");
  AST_RD_SETUP: assert property ($fell(oe) |-> !$past(ce, 2))
    else $error("read address setup");
endmodule : fsp_host_asserts
bind fsp_host fsp_host_asserts fsp_host_asserts_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .flash_pins_out(flash_pins_out));
`default_nettype wire

// File: tb/fsp_host_tb.sv
// Purpose: Register-level bench for the protection host.
// Assumes: Device model answers at once.
// Notes:   Each op is polled to idle; v then holds STATUS.
`timescale 1ns/100ps
`default_nettype none
module fsp_host_tb import fsp_pkg::*;;
  `define CK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, s); end end
  // ----
  // Harness
  // ----
  logic              sys_clk_in = 1'b0, rst_in, reg_wr_in, reg_rd_in, accel_out;
  logic [REG_AW-1:0] reg_addr_in;
  logic [REG_DW-1:0] reg_wdata_in, reg_rdata_out, v;
  logic [DATA_W-1:0] flash_dq_in;
  fsp_pins_s         pins;
  int                err_count = 0, n_compared = 0, cyc = 0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  fsp_host fsp_host_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .flash_dq_in(flash_dq_in), .flash_pins_out(pins),
    .accel_out(accel_out));
  fsp_flash_model fsp_flash_model_i (.pins_in(pins), .accel_in(accel_out), .dq_out(flash_dq_in));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask : rd
  // Busy may lag the command write, so polling starts two clocks later
  task automatic op(input logic [3:0] c);
    wr(REG_CMD, {28'h0, c});
    repeat (2) @(posedge sys_clk_in);
    for (int i = 0; i < 100; i++) begin
      rd(REG_STATUS);
      if (v[ST_BUSY] === 1'b0) break;
    end
    `CK("busy", 1'b0, v[ST_BUSY])
  endtask : op
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      $display("mismatch timeout exp %0d got %0d", 20000, cyc);
      err_count++;
      summarize();
    end
  end
  initial begin
    rst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    #1 `CK("idle", 4'hf, {pins.dq_oe_n, pins.ce_n, pins.we_n, pins.oe_n})
    op(4'h0);
    `CK("mode", 3'h1, v[6:4])
    wr(REG_WDATA, 32'h1234);
    op(4'h7);
    op(4'h9);
    rd(REG_RDATA);
    `CK("lock", 32'h1234, v)
    op(4'h5);
    `CK("mode", 3'h0, v[6:4])
    op(4'h5);
    `CK("err", 1'b1, v[ST_ERR])
    wr(REG_STATUS, 32'h2);
    op(4'h1);
    for (int i = 0; i < 4; i++) begin
      wr(REG_ADDR, 32'(i));
      wr(REG_WDATA, 32'h1a00 + 32'(i));
      op(4'h7);
    end
    op(4'h9);
    for (int i = 0; i < 4; i++) begin
      rd(REG_PWD0 + 8'(4 * i));
      `CK("pwd", 32'h1a00 + 32'(i), v)
    end
    op(4'ha);
    op(4'h9);
    rd(REG_RDATA);
    `CK("unlock", 32'h1a03, v)
    op(4'h5);
    wr(REG_ADDR, 32'h18000);
    rd(REG_ADDR);
    `CK("addr", 32'h18000, v)
    op(4'h2);
    op(4'h7);
    op(4'h9);
    `CK("nv", 1'b0, v[ST_DQ0])
    op(4'hb);
    op(4'h9);
    `CK("nv", 1'b1, v[ST_DQ0])
    op(4'h5);
    op(4'h3);
    op(4'h7);
    op(4'h9);
    `CK("frz", 1'b0, v[ST_DQ0])
    op(4'h5);
    op(4'h4);
    op(4'h7);
    op(4'h9);
    `CK("vol", 1'b0, v[ST_DQ0])
    op(4'h8);
    op(4'h9);
    `CK("vol", 1'b1, v[ST_DQ0])
    op(4'h6);
    `CK("mode", 3'h0, v[6:4])
    summarize();
  end
endmodule : fsp_host_tb
`default_nettype wire
